// file: reset_cause_pkg.sv
// constants and types for the reset cause and start-up delay block
package reset_cause_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CAUSE = 5'h00;
  localparam logic [4:0] OFS_CONFIG = 5'h04;
  localparam logic [4:0] OFS_CORESTAT = 5'h08;
  localparam logic [4:0] OFS_IRQSTAT = 5'h0c;
  localparam logic [4:0] OFS_IRQMASK = 5'h10;
  // field positions
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_POWERON = 1;
  localparam int BIT_TIMEOUT = 0;
  localparam int BIT_POWERDOWN = 1;
  localparam int EVT_POR = 0;
  localparam int EVT_BOR = 1;
  localparam int EVT_PIN = 2;
  localparam int EVT_WDT = 3;
  localparam int EVT_WAKE = 4;
  localparam int EVT_W = 5;
  localparam int PC_W = 13;
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int POWERUP_DELAY_COUNTER_MS = 72;
  localparam int POWERUP_DELAY_COUNTER_CYCLES = POWERUP_DELAY_COUNTER_MS * 1000 * (1000000 / CLK_PERIOD_PS);
  localparam int CPU_START_US = 5;
  localparam int CPU_START_CYCLES = (CPU_START_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OST_PERIODS = 1024;
  // fixed addresses
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_IRQ_VECTOR = 13'h0004;
  typedef enum logic [1:0] {
    OSC_CRYSTAL,
    OSC_RC,
    OSC_SECONDARY
  } osc_mode_t;
  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_POWER,
    CLS_PINWDT,
    CLS_WAKE
  } reset_class_t;
  typedef struct packed {
    osc_mode_t oscMode;
    logic brownoutEnable;
    logic powerupDelayDisable;
  } cfg_t;
  localparam cfg_t CFG_RESET = '{oscMode: OSC_RC, brownoutEnable: 1'b1, powerupDelayDisable: 1'b1};
  typedef struct packed {
    logic load;
    reset_class_t cls;
    logic [PC_W-1:0] value;
    logic clearTopStatus;
  } pc_cmd_t;
endpackage

// file: reset_cause_and_startup_delay.sv
// reset cause recording, start-up delay sequencing and avalon register slave
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_startup_delay #(
  parameter int POWERUP_DELAY_COUNTER_COUNT = reset_cause_pkg::POWERUP_DELAY_COUNTER_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // reset and wake sources
  input wire logic porEvt,
  input wire logic borEvt,
  input wire logic externalResetPinN,
  input wire logic watchdogEvt,
  input wire logic irqWakeEvt,
  input wire logic [7:0] irqWakeSrc,
  input wire logic oscTick,
  // processor core
  input wire logic sleeping,
  input wire logic globalIrqEnable,
  input wire logic [reset_cause_pkg::PC_W-1:0] pcCurrent,
  output logic coreHold,
  output reset_cause_pkg::pc_cmd_t pcCmd,
  output logic [7:0] irqFlagSet,
  output logic timeoutFlag,
  output logic powerdownFlag,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // interrupt
  output logic irq
);
  import reset_cause_pkg::*;

  typedef enum logic [2:0] {
    S_RUN,
    S_PIN,
    S_POWERUP_DELAY_COUNTER,
    S_OST,
    S_CPU
  } seq_state_t;

  localparam int POWERUP_DELAY_COUNTER_W = $clog2(POWERUP_DELAY_COUNTER_COUNT + 1);
  localparam int OST_W = $clog2(OST_PERIODS + 1);
  localparam int CPU_W = $clog2(CPU_START_CYCLES + 1);

  seq_state_t state_r;
  cfg_t cfg_r;
  logic pinSync1_r, pinSync2_r, pinSync3_r;
  logic borFlag_r, porFlag_r;
  logic [POWERUP_DELAY_COUNTER_W-1:0] pwrtCnt_r;
  logic [OST_W-1:0] ostCnt_r;
  logic [CPU_W-1:0] cpuCnt_r;
  reset_class_t pendClass_r;
  logic [PC_W-1:0] pendPc_r;
  logic pendIrqWake_r;
  logic [7:0] pendSrc_r;
  logic [EVT_W-1:0] irqStat_r, irqMask_r;
  logic waitReq_r;
  logic [31:0] rdata_r;

  // event arbitration, power-on first
  logic evPor, evBor, evPin, evWdtRst, evWake, evWdtWake, evIrqWake;
  logic pinLow, needPwrt, needOst, cpuDone, busAck, wrAck;
  logic [EVT_W-1:0] evVec;

  assign pinLow = !pinSync2_r;
  assign evPor = porEvt;
  assign evBor = borEvt && cfg_r.brownoutEnable && !evPor;
  assign evPin = !pinSync2_r && pinSync3_r && !evPor && !evBor;
  assign evWdtRst = watchdogEvt && !sleeping && state_r == S_RUN && !evPor && !evBor && !evPin;
  assign evWdtWake = watchdogEvt && sleeping && state_r == S_RUN && !evPor && !evBor && !evPin;
  assign evIrqWake = irqWakeEvt && sleeping && state_r == S_RUN && !evPor && !evBor && !evPin && !watchdogEvt;
  assign evWake = evWdtWake || evIrqWake;
  assign evVec = {evWake, evWdtRst || evWdtWake, evPin, evBor, evPor};
  assign needPwrt = (evPor || evBor) && !cfg_r.powerupDelayDisable;
  assign needOst = cfg_r.oscMode == OSC_CRYSTAL;
  assign cpuDone = cpuCnt_r == '0;
  assign busAck = (read || write) && waitReq_r;
  assign wrAck = write && !waitReq_r;

  // pin synchroniser; the third stage only feeds the edge detector
  always_ff @(posedge clk) begin
    if (srst) begin
      pinSync1_r <= 1'b1;
      pinSync2_r <= 1'b1;
      pinSync3_r <= 1'b1;
    end else begin
      pinSync1_r <= externalResetPinN;
      pinSync2_r <= pinSync1_r;
      pinSync3_r <= pinSync2_r;
    end
  end

  // cause flags: srst stands for the power-on detector itself
  always_ff @(posedge clk) begin
    if (srst || evPor) begin
      porFlag_r <= 1'b0;
      borFlag_r <= 1'b0;
    end else begin
      if (wrAck && address == OFS_CAUSE && byteenable[0]) begin
        porFlag_r <= writedata[BIT_POWERON];
        borFlag_r <= writedata[BIT_BROWNOUT];
      end
      // hardware clear wins over a software write in the same cycle
      if (evBor) begin
        borFlag_r <= 1'b0;
      end
    end
  end

  // timeout and power-down status flags
  always_ff @(posedge clk) begin
    if (srst || evPor || evBor) begin
      timeoutFlag <= 1'b1;
      powerdownFlag <= 1'b1;
    end else if (evWdtRst) begin
      timeoutFlag <= 1'b0;
      powerdownFlag <= 1'b1;
    end else if (evWdtWake) begin
      timeoutFlag <= 1'b0;
      powerdownFlag <= 1'b0;
    end else if ((evPin && sleeping) || evIrqWake) begin
      timeoutFlag <= 1'b1;
      powerdownFlag <= 1'b0;
    end
  end

  // start-up sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      // power-on takes the delay path of the reset configuration
      if (!CFG_RESET.powerupDelayDisable) begin
        state_r <= S_POWERUP_DELAY_COUNTER;
      end else if (CFG_RESET.oscMode == OSC_CRYSTAL) begin
        state_r <= S_OST;
      end else begin
        state_r <= S_CPU;
      end
      pendClass_r <= CLS_POWER;
      pendPc_r <= PC_RESET;
      pendIrqWake_r <= 1'b0;
      pendSrc_r <= 8'h00;
    end else if (evPor || evBor || evWake) begin
      // reset re-entry restarts the oscillator and cpu timers; the power-up delay counter reloads only on power-on and brown-out
      pendClass_r <= evWake ? CLS_WAKE : CLS_POWER;
      pendIrqWake_r <= evIrqWake;
      pendSrc_r <= irqWakeSrc;
      if (evIrqWake && globalIrqEnable) begin
        pendPc_r <= PC_IRQ_VECTOR;
      end else if (evWake) begin
        pendPc_r <= PC_W'(pcCurrent + 1'b1);
      end else begin
        pendPc_r <= PC_RESET;
      end
      if (needPwrt) begin
        state_r <= S_POWERUP_DELAY_COUNTER;
      end else if (needOst) begin
        state_r <= S_OST;
      end else begin
        state_r <= S_CPU;
      end
    end else if (evPin || evWdtRst) begin
      pendClass_r <= CLS_PINWDT;
      pendPc_r <= PC_RESET;
      pendIrqWake_r <= 1'b0;
      state_r <= evPin ? S_PIN : S_CPU;
    end else begin
      case (state_r)
        S_PIN: begin
          if (!pinLow) begin
            state_r <= S_CPU;
          end
        end
        S_POWERUP_DELAY_COUNTER: begin
          if (pwrtCnt_r == '0) begin
            state_r <= needOst ? S_OST : S_CPU;
          end
        end
        S_OST: begin
          if (ostCnt_r == '0) begin
            state_r <= S_CPU;
          end
        end
        S_CPU: begin
          if (cpuDone) begin
            state_r <= S_RUN;
          end
        end
        default: begin
          state_r <= S_RUN;
        end
      endcase
    end
  end

  // power-up delay counter, loaded on entry
  always_ff @(posedge clk) begin
    if (srst || evPor || evBor) begin
      pwrtCnt_r <= POWERUP_DELAY_COUNTER_W'(POWERUP_DELAY_COUNTER_COUNT - 1);
    end else if (state_r == S_POWERUP_DELAY_COUNTER && pwrtCnt_r != '0) begin
      pwrtCnt_r <= pwrtCnt_r - 1'b1;
    end
  end

  // oscillator settle counter runs on oscillator period ticks
  always_ff @(posedge clk) begin
    if (srst || evPor || evBor || evWake) begin
      ostCnt_r <= OST_W'(OST_PERIODS);
    end else if (state_r == S_OST && oscTick && ostCnt_r != '0) begin
      ostCnt_r <= ostCnt_r - 1'b1;
    end
  end

  // cpu start delay counts from the event, in parallel with the timers
  always_ff @(posedge clk) begin
    if (srst || evPor || evBor || evWake) begin
      cpuCnt_r <= CPU_W'(CPU_START_CYCLES);
    end else if (!cpuDone) begin
      cpuCnt_r <= cpuCnt_r - 1'b1;
    end
  end

  // core handoff: hold, program counter load, wake flags
  always_ff @(posedge clk) begin
    if (srst) begin
      coreHold <= 1'b1;
      pcCmd <= '0;
      irqFlagSet <= 8'h00;
    end else begin
      coreHold <= state_r != S_RUN || evPor || evBor || evPin || evWdtRst || evWake;
      pcCmd.load <= 1'b0;
      irqFlagSet <= 8'h00;
      if (state_r == S_CPU && cpuDone && !(evPor || evBor || evPin || evWdtRst || evWake)) begin
        pcCmd.load <= 1'b1;
        pcCmd.cls <= pendClass_r;
        pcCmd.value <= pendPc_r;
        pcCmd.clearTopStatus <= pendClass_r != CLS_WAKE;
        if (pendIrqWake_r) begin
          irqFlagSet <= pendSrc_r;
        end
      end
    end
  end

  // avalon slave: one wait state, then a one-cycle acknowledge
  always_ff @(posedge clk) begin
    if (srst) begin
      waitReq_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      waitReq_r <= !busAck;
      if (busAck && read) begin
        if (address == OFS_CAUSE) begin
          rdata_r <= {30'h0, porFlag_r, borFlag_r};
        end else if (address == OFS_CONFIG) begin
          rdata_r <= {28'h0, cfg_r};
        end else if (address == OFS_CORESTAT) begin
          rdata_r <= {30'h0, powerdownFlag, timeoutFlag};
        end else if (address == OFS_IRQSTAT) begin
          rdata_r <= {27'h0, irqStat_r};
        end else if (address == OFS_IRQMASK) begin
          rdata_r <= {27'h0, irqMask_r};
        end else begin
          rdata_r <= 32'h0000_0000;
        end
      end
    end
  end
  assign waitrequest = waitReq_r;
  assign readdata = rdata_r;

  // configuration register
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r <= CFG_RESET;
    end else if (wrAck && address == OFS_CONFIG && byteenable[0]) begin
      cfg_r <= writedata[3:0];
    end
  end

  // sticky event status, write one to clear; a new event wins
  always_ff @(posedge clk) begin
    if (srst) begin
      irqStat_r <= '0;
      irqMask_r <= '0;
      irq <= 1'b0;
    end else begin
      if (wrAck && address == OFS_IRQSTAT && byteenable[0]) begin
        irqStat_r <= (irqStat_r & ~writedata[EVT_W-1:0]) | evVec;
      end else begin
        irqStat_r <= irqStat_r | evVec;
      end
      if (wrAck && address == OFS_IRQMASK && byteenable[0]) begin
        irqMask_r <= writedata[EVT_W-1:0];
      end
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // age since the last event that owes the cpu delay; saturates so it cannot wrap
  logic [CPU_W:0] startAge_r;
  always_ff @(posedge clk) begin
    if (srst || evPor || evBor || evWake) begin
      startAge_r <= '0;
    end else if (startAge_r != '1) begin
      startAge_r <= startAge_r + 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_por_flags_set: assert property (porEvt |=> !porFlag_r && timeoutFlag && powerdownFlag)
    else $error("power-on did not set status flags");
  a_bor_flag_clear: assert property (evBor |=> !borFlag_r && porFlag_r == $past(porFlag_r))
    else $error("brown-out flag handling wrong");
  a_wdt_reset_flags: assert property (evWdtRst |=> !timeoutFlag && powerdownFlag)
    else $error("watchdog reset flags wrong");
  a_irq_wake_flags: assert property (evIrqWake |=> timeoutFlag && !powerdownFlag)
    else $error("irq wake flags wrong");
  a_pin_keeps_flags: assert property (evPin && !sleeping |=> $stable(timeoutFlag) && $stable(powerdownFlag))
    else $error("pin reset changed status flags");
  a_reset_pc_zero: assert property (pcCmd.load && pcCmd.cls != CLS_WAKE |-> pcCmd.value == PC_RESET)
    else $error("true reset did not start at zero");
  a_cause_upper_zero: assert property (read && !waitrequest && address == OFS_CAUSE |-> readdata[31:2] == '0)
    else $error("unimplemented bits not zero");
  a_ost_holds_core: assert property (state_r == S_OST |=> coreHold)
    else $error("core released during oscillator wait");
  a_cpu_delay_done: assert property (pcCmd.load && pcCmd.cls != CLS_PINWDT |->
    startAge_r >= CPU_START_CYCLES) else $error("start delay skipped");
  a_wake_no_powerup_delay_counter: assert property (evWake |=> state_r != S_POWERUP_DELAY_COUNTER)
    else $error("wake ran power-up delay");
  a_wdt_wake_flags: assert property (evWdtWake |=> !timeoutFlag && !powerdownFlag)
    else $error("watchdog wake flags wrong");
  a_pin_sleep_flags: assert property (evPin && sleeping |=> timeoutFlag && !powerdownFlag)
    else $error("pin reset in sleep flags wrong");
  a_por_flag_kept: assert property (!evPor && !(wrAck && address == OFS_CAUSE) |=>
    porFlag_r == $past(porFlag_r)) else $error("power-on flag changed without power-on");
endmodule
`default_nettype wire

// file: reset_source_model.sv
// far-side model: reset detectors, oscillator tick and core state
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
  // clock
  input wire logic clk,
  // detectors
  output logic porEvt,
  output logic borEvt,
  output logic pinN,
  output logic wdtEvt,
  output logic irqWake,
  output logic [7:0] irqSrc,
  output logic oscTick,
  // core state
  output logic sleeping,
  output logic global_irq_enable,
  output logic [12:0] pcCur
);
  logic [1:0] div = 2'h0;
  logic [7:0] held = 8'h00;
  initial begin
    {porEvt, borEvt, wdtEvt, irqWake, oscTick, sleeping, global_irq_enable} = 7'h00;
    pinN = 1'b1;
    irqSrc = 8'hff;
    pcCur = 13'h0000;
  end
  // one oscillator period every fourth clock
  always @(posedge clk) begin
    div <= div + 2'h1;
    oscTick <= (div == 2'h3);
  end
  task automatic core(input logic s, input logic g, input logic [12:0] p, input logic [7:0] f);
    @(posedge clk);
    sleeping <= s;
    global_irq_enable <= g;
    pcCur <= p;
    held <= f;
  endtask
  // pin is held low past the two-stage synchroniser
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: porEvt <= 1'b1;
      1: borEvt <= 1'b1;
      2: pinN <= 1'b0;
      3: wdtEvt <= 1'b1;
      default: begin
        irqWake <= 1'b1;
        irqSrc <= held;
      end
    endcase
    repeat (k == 2 ? 6 : 1) @(posedge clk);
    {porEvt, borEvt, wdtEvt, irqWake} <= 4'h0;
    pinN <= 1'b1;
    irqSrc <= ~held;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the reset cause and start-up delay block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import reset_cause_pkg::*;
  typedef struct packed {logic [PC_W-1:0] pc; reset_class_t cls; logic top, to, pd; logic [7:0] flg;} exp_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic porEvt, borEvt, pinN, wdtEvt, irqWake, oscTick, sleeping, global_irq_enable, coreHold, toFlag, pdFlag, waitrequest, irq;
  logic [7:0] irqSrc, irqFlagSet, f;
  logic [PC_W-1:0] pcCur, p;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, rd;
  pc_cmd_t pcCmd;
  exp_t expQ[$];
  exp_t e;
  int miscompares = 0, checked = 0, cycles = 0, n, rel;
  always #2 clk = ~clk;
  reset_source_model src (.clk(clk), .porEvt(porEvt), .borEvt(borEvt), .pinN(pinN), .wdtEvt(wdtEvt),
    .irqWake(irqWake), .irqSrc(irqSrc), .oscTick(oscTick), .sleeping(sleeping), .global_irq_enable(global_irq_enable), .pcCur(pcCur));
  reset_cause_and_startup_delay #(.POWERUP_DELAY_COUNTER_COUNT(20)) uut (.clk(clk), .srst(srst), .porEvt(porEvt),
    .borEvt(borEvt), .externalResetPinN(pinN), .watchdogEvt(wdtEvt), .irqWakeEvt(irqWake),
    .irqWakeSrc(irqSrc), .oscTick(oscTick), .sleeping(sleeping), .globalIrqEnable(global_irq_enable),
    .pcCurrent(pcCur), .coreHold(coreHold), .pcCmd(pcCmd), .irqFlagSet(irqFlagSet),
    .timeoutFlag(toFlag), .powerdownFlag(pdFlag), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) check("bus wait", 32'(n), 32'h2);
  endtask
  task automatic step(input int k, input logic [PC_W-1:0] pc, input reset_class_t cls, input logic [2:0] tpf,
      input logic [7:0] flg, input logic [31:0] cause, input string nm);
    expQ.push_back('{pc, cls, tpf[2], tpf[1], tpf[0], flg});
    src.pulse(k);
    rel = 0;
    do begin
      @(posedge clk);
      rel++;
      if (rel == 2) check("core held", 32'(coreHold), 32'h1);
    end while (pcCmd.load !== 1'b1 && rel < 6000);
    check("release wait", 32'(rel < 6000), 32'h1);
    repeat (3) @(posedge clk);
    check("core free", 32'(coreHold), 32'h0);
    bus(1'b0, OFS_CAUSE, 32'h0);
    check("cause", rd, cause);
    bus(1'b1, OFS_CAUSE, 32'h3);
    $display("test %s done", nm);
  endtask
  // every release is compared against the oldest expectation
  always @(posedge clk) begin
    if (!srst && pcCmd.load === 1'b1) begin
      if (expQ.size() == 0) begin
        check("release count", 32'h1, 32'h0);
      end else begin
        e = expQ.pop_front();
        check("release", 32'({pcCmd.value, pcCmd.cls, pcCmd.clearTopStatus, toFlag, pdFlag, irqFlagSet}),
          32'(e));
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h8386));
    p = 13'($urandom);
    f = 8'($urandom) | 8'h01;
    expQ.push_back('{PC_RESET, CLS_POWER, 1'b1, 1'b1, 1'b1, 8'h00});
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rel = 0;
    while (pcCmd.load !== 1'b1 && rel < 3000) begin
      @(posedge clk);
      rel++;
    end
    check("powerup delay", 32'(rel >= 1250 && rel < 3000), 32'h1);
    repeat (3) @(posedge clk);
    bus(1'b0, OFS_CORESTAT, 32'h0);
    check("status", rd, 32'h3);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, OFS_CAUSE, 32'hffffffff);
    bus(1'b0, OFS_CAUSE, 32'h0);
    check("cause", rd, 32'h3);
    $display("test registers done");
    step(1, PC_RESET, CLS_POWER, 3'b111, 8'h00, 32'h2, "brownout");
    bus(1'b1, OFS_IRQMASK, 32'h0);
    repeat (3) @(posedge clk);
    check("irq masked", 32'(irq), 32'h0);
    bus(1'b0, OFS_IRQSTAT, 32'h0);
    check("irq status", rd & 32'h2, 32'h2);
    bus(1'b1, OFS_IRQMASK, 32'h2);
    repeat (3) @(posedge clk);
    check("irq raised", 32'(irq), 32'h1);
    bus(1'b1, OFS_IRQSTAT, 32'h1f);
    repeat (3) @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    $display("test interrupt done");
    step(2, PC_RESET, CLS_PINWDT, 3'b111, 8'h00, 32'h3, "pin");
    step(3, PC_RESET, CLS_PINWDT, 3'b101, 8'h00, 32'h3, "watchdog");
    bus(1'b1, OFS_CONFIG, 32'h3);
    src.core(1'b1, 1'b0, p, f);
    step(3, p + 13'h1, CLS_WAKE, 3'b000, 8'h00, 32'h3, "watchdog wake");
    check("oscillator wait", 32'(rel >= 4096 && rel < 4096 + 1250), 32'h1);
    bus(1'b1, OFS_CONFIG, 32'h7);
    step(4, p + 13'h1, CLS_WAKE, 3'b010, f, 32'h3, "irq wake");
    src.core(1'b1, 1'b1, p, f);
    bus(1'b1, OFS_CONFIG, 32'hb);
    step(4, PC_IRQ_VECTOR, CLS_WAKE, 3'b010, f, 32'h3, "irq vector");
    check("secondary wake", 32'(rel >= 1250 && rel < 4096), 32'h1);
    step(2, PC_RESET, CLS_PINWDT, 3'b110, 8'h00, 32'h3, "pin in sleep");
    src.core(1'b0, 1'b0, p, f);
    bus(1'b1, OFS_CONFIG, 32'h5);
    src.pulse(1);
    repeat (4) @(posedge clk);
    check("brownout ignored", 32'(coreHold), 32'h0);
    $display("test brownout disabled done");
    bus(1'b1, OFS_CONFIG, 32'h2);
    step(0, PC_RESET, CLS_POWER, 3'b111, 8'h00, 32'h0, "poweron");
    check("powerup timer", 32'(rel >= 20 + 4096 && rel < 20 + 4096 + 1250), 32'h1);
    check("pending", 32'(expQ.size()), 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
